// ---- hdl/comp_ctrl.sv ----
// Comparator control and status block with AXI4-Lite register port
`timescale 1ns/1ps
`default_nettype none
module comp_ctrl (
  // Clock and reset
  input  wire logic                                core_clk,
  input  wire logic                                rst_b,
  // AXI4-Lite write address
  input  wire logic [comp_pkg::REG_ADDR_W-1:0]     awaddr,
  input  wire logic                                awvalid,
  output logic                                     awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                         wdata,
  input  wire logic [3:0]                          wstrb,
  input  wire logic                                wvalid,
  output logic                                     wready,
  // AXI4-Lite write response
  output logic [1:0]                               bresp,
  output logic                                     bvalid,
  input  wire logic                                bready,
  // AXI4-Lite read address
  input  wire logic [comp_pkg::REG_ADDR_W-1:0]     araddr,
  input  wire logic                                arvalid,
  output logic                                     arready,
  // AXI4-Lite read data
  output logic [31:0]                              rdata,
  output logic [1:0]                               rresp,
  output logic                                     rvalid,
  input  wire logic                                rready,
  // Analog comparator core
  input  wire logic                                comp_raw,
  output var comp_pkg::core_ctrl_t                 core_ctrl,
  // Comparator output pin
  output var comp_pkg::pin_out_t                   comparator_out_pin,
  // Power manager state
  input  wire comp_pkg::power_mode_t               power_mode,
  // Timer capture routing
  output logic                                     capture_ch0,
  output logic                                     capture_pin_blocked,
  // Interrupt request
  output logic                                     irq
);
  import comp_pkg::*;

  // Address decode shared by read and write paths
  function automatic reg_sel_t decode(input logic [REG_ADDR_W-1:0] addr);
    if (addr[REG_ADDR_W-1:2] == CSR_OFFSET[REG_ADDR_W-1:2]) begin
      decode = SEL_CSR;
    end else if (addr[REG_ADDR_W-1:2] == IRQ_STATUS_OFFSET[REG_ADDR_W-1:2]) begin
      decode = SEL_STATUS;
    end else if (addr[REG_ADDR_W-1:2] == IRQ_CLEAR_OFFSET[REG_ADDR_W-1:2]) begin
      decode = SEL_CLEAR;
    end else if (addr[REG_ADDR_W-1:2] == IRQ_ENABLE_OFFSET[REG_ADDR_W-1:2]) begin
      decode = SEL_ENABLE;
    end else if (addr[REG_ADDR_W-1:2] == SYSOPT_OFFSET[REG_ADDR_W-1:2]) begin
      decode = SEL_SYSOPT;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // Control state
  logic                  enable;
  logic                  ref_sel;
  logic                  flag;
  logic                  irq_en;
  logic                  out_en;
  logic [1:0]            edge_sel;
  logic                  route;
  logic [IRQ_W-1:0]      irq_status;
  logic [IRQ_W-1:0]      irq_mask;
  power_mode_t           mode_prev;

  // Bus holding state
  logic                  aw_held;
  logic                  w_held;
  logic [REG_ADDR_W-1:0] aw_addr;
  logic [7:0]            w_byte;
  logic                  w_lane0;

  // Comparator path
  logic                  settled;
  logic                  compare_event;

  // Bus handshakes
  wire logic aw_take     = awvalid & awready;
  wire logic w_take      = wvalid & wready;
  wire logic ar_take     = arvalid & arready;
  wire logic write_fire  = aw_held & w_held & ~bvalid;
  wire logic next_aw_held = (aw_held | aw_take) & ~write_fire;
  wire logic next_w_held  = (w_held | w_take) & ~write_fire;
  wire logic next_bvalid  = write_fire | (bvalid & ~bready);
  wire logic next_rvalid  = ar_take | (rvalid & ~rready);

  // Write and read decode
  wire reg_sel_t wr_sel   = decode(aw_addr);
  wire reg_sel_t rd_sel   = decode(araddr);
  wire logic     csr_wr   = write_fire & w_lane0 & (wr_sel == SEL_CSR);
  wire logic     clr_wr   = write_fire & w_lane0 & (wr_sel == SEL_CLEAR);
  wire logic     mask_wr  = write_fire & w_lane0 & (wr_sel == SEL_ENABLE);
  wire logic     route_wr = write_fire & w_lane0 & (wr_sel == SEL_SYSOPT);

  // any stop mode silences the comparator
  wire logic stopped   = (power_mode != MODE_RUN);
  wire logic eff_en    = enable & ~stopped;
  // leaving deep stop restores the control register's reset state
  wire logic deep_wake = (mode_prev == MODE_DEEP_STOP) & (power_mode != MODE_DEEP_STOP);

  // result forced low while disabled; high means plus above minus
  wire logic live_result = eff_en & settled;

  // one 8-bit register holds the comparator control and status bits; interrupt status, mask and route sit elsewhere
  wire csr_t csr_view = '{enable: enable, ref_select: ref_sel, flag: flag, irq_enable: irq_en,
                          result: live_result, out_pin_enable: out_en, edge_select: edge_sel};

  // Read data mux, registers sit in the low bits
  wire logic [31:0] read_word =
    (rd_sel == SEL_CSR)    ? {24'h000000, csr_view} :
    (rd_sel == SEL_STATUS) ? {{(32 - IRQ_W){1'b0}}, irq_status} :
    (rd_sel == SEL_ENABLE) ? {{(32 - IRQ_W){1'b0}}, irq_mask} :
    (rd_sel == SEL_SYSOPT) ? {31'h00000000, route} : 32'h00000000;

  wire logic next_flag = compare_event | (flag & ~(csr_wr & w_byte[FLAG_POS]));

  // Sticky events; a new event beats a same-cycle clear
  wire logic [IRQ_W-1:0] events     = {deep_wake, compare_event};
  wire logic [IRQ_W-1:0] clear_mask = clr_wr ? w_byte[IRQ_W-1:0] : {IRQ_W{1'b0}};
  wire logic [IRQ_W-1:0] next_status = (irq_status & ~clear_mask) | events;

  // compare interrupt needs its own enable bit; with it set, the flag alone or the masked event bit raises it
  wire logic next_irq = (irq_en & (flag | (irq_status[IRQ_EVENT_BIT] & irq_mask[IRQ_EVENT_BIT])))
                      | (irq_status[IRQ_WAKE_BIT] & irq_mask[IRQ_WAKE_BIT]);

  // settle the raw comparator level first
  comp_sync #(
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .async_in (comp_raw),
    .settled  (settled)
  );

  // edge events only while running and enabled
  comp_edge u_edge (
    .core_clk    (core_clk),
    .rst_b       (rst_b),
    .level       (settled),
    .armed       (eff_en),
    .edge_select (edge_sel),
    .hit         (compare_event)
  );

  // Write channel capture; address and data may arrive in either order
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      aw_addr <= '0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= ~next_aw_held & ~next_bvalid;
      wready  <= ~next_w_held & ~next_bvalid;
      if (aw_take) begin
        aw_addr <= awaddr;
      end
      if (w_take) begin
        w_byte  <= wdata[7:0];
        w_lane0 <= wstrb[0];
      end
    end
  end

  // Write response; unmapped words answer with a slave error
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else begin
      bvalid <= next_bvalid;
      if (write_fire) begin
        bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // read data captured at the edge the address is taken
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_take) begin
        rdata <= read_word;
        rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end

  // reset and deep wake clear the control register
  always_ff @(posedge core_clk) begin
    if (!rst_b || deep_wake) begin
      enable   <= CSR_RESET[ENABLE_POS];
      ref_sel  <= CSR_RESET[REF_SEL_POS];
      irq_en   <= CSR_RESET[IRQ_EN_POS];
      out_en   <= CSR_RESET[OUT_EN_POS];
      edge_sel <= CSR_RESET[EDGE_SEL_LSB +: 2];
      flag     <= CSR_RESET[FLAG_POS];
    end else begin
      if (csr_wr) begin
        enable   <= w_byte[ENABLE_POS];
        ref_sel  <= w_byte[REF_SEL_POS];
        irq_en   <= w_byte[IRQ_EN_POS];
        out_en   <= w_byte[OUT_EN_POS];
        edge_sel <= w_byte[EDGE_SEL_LSB +: 2];
      end
      flag <= next_flag;
    end
  end

  // Interrupt registers and route option, kept across deep stop
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_status <= IRQ_RESET;
      irq_mask   <= IRQ_RESET;
      route      <= SYSOPT_RESET;
      mode_prev  <= MODE_RUN;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_status;
      if (mask_wr) begin
        irq_mask <= w_byte[IRQ_W-1:0];
      end
      if (route_wr) begin
        route <= w_byte[ROUTE_POS];
      end
      mode_prev <= power_mode;
      irq       <= next_irq;
    end
  end

  // Registered outputs towards core, pin and timer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      core_ctrl           <= '0;
      comparator_out_pin  <= '0;
      capture_ch0         <= 1'b0;
      capture_pin_blocked <= 1'b0;
    end else begin
      core_ctrl.power_on   <= eff_en;
      core_ctrl.ref_select <= ref_sel;
      // pin shows the result only when enabled
      comparator_out_pin.level <= out_en & live_result;
      comparator_out_pin.oe    <= out_en;
      // capture channel fed from the comparator
      capture_ch0         <= route & live_result;
      capture_pin_blocked <= route;
    end
  end

  // Checks on the behaviour above
  sequence s_csr_write;
    csr_wr && !deep_wake;
  endsequence

  sequence s_csr_read;
    ar_take && (rd_sel == SEL_CSR);
  endsequence

  property p_flag_set;
    @(posedge core_clk) disable iff (!rst_b)
    (compare_event && !deep_wake) |=> flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("compare event did not set the flag");

  property p_flag_clear;
    @(posedge core_clk) disable iff (!rst_b)
    s_csr_write ##0 (w_byte[FLAG_POS] && !compare_event) |=> !flag;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("write of one did not clear the flag");

  property p_flag_keep;
    @(posedge core_clk) disable iff (!rst_b)
    s_csr_write ##0 (flag && !w_byte[FLAG_POS]) |=> flag;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("write of zero disturbed the flag");

  property p_irq_follow;
    @(posedge core_clk) disable iff (!rst_b)
    (flag && irq_en) |=> irq;
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("flag with enable gave no interrupt");

  property p_irq_masked;
    @(posedge core_clk) disable iff (!rst_b)
    (!irq_en && !(irq_status[IRQ_WAKE_BIT] && irq_mask[IRQ_WAKE_BIT])) |=> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("interrupt raised while disabled");

  property p_no_event_off;
    @(posedge core_clk) disable iff (!rst_b)
    !eff_en |-> !compare_event;
  endproperty
  a_no_event_off: assert property (p_no_event_off) else $error("event while disabled or stopped");

  property p_stop_powers_down;
    @(posedge core_clk) disable iff (!rst_b)
    stopped |=> !core_ctrl.power_on;
  endproperty
  a_stop_powers_down: assert property (p_stop_powers_down) else $error("core powered in stop");

  property p_read_result;
    @(posedge core_clk) disable iff (!rst_b)
    s_csr_read |=> (rdata[RESULT_POS] == $past(settled && eff_en));
  endproperty
  a_read_result: assert property (p_read_result) else $error("result bit not the live level");

  property p_result_zero;
    @(posedge core_clk) disable iff (!rst_b)
    s_csr_read ##0 !enable |=> !rdata[RESULT_POS];
  endproperty
  a_result_zero: assert property (p_result_zero) else $error("result read nonzero while disabled");

  property p_pin_off;
    @(posedge core_clk) disable iff (!rst_b)
    !out_en |=> (!comparator_out_pin.oe && !comparator_out_pin.level);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven with output disabled");

  property p_edge_both;
    @(posedge core_clk) disable iff (!rst_b)
    (eff_en && edge_sel == EDGE_BOTH) [*2] ##0 $changed(settled) |-> compare_event;
  endproperty
  a_edge_both: assert property (p_edge_both) else $error("toggle missed in either-edge mode");

  property p_deep_wake;
    @(posedge core_clk) disable iff (!rst_b)
    deep_wake |=> (!enable && !irq_en && !flag && !out_en);
  endproperty
  a_deep_wake: assert property (p_deep_wake) else $error("deep wake left settings in place");

  property p_light_keep;
    @(posedge core_clk) disable iff (!rst_b)
    (power_mode == MODE_LIGHT_STOP && !csr_wr && !deep_wake) |=> $stable(enable) && $stable(edge_sel);
  endproperty
  a_light_keep: assert property (p_light_keep) else $error("light stop lost settings");

  property p_route;
    @(posedge core_clk) disable iff (!rst_b)
    route |=> (capture_pin_blocked && capture_ch0 == $past(live_result));
  endproperty
  a_route: assert property (p_route) else $error("capture routing not applied");

  property p_ref_select;
    @(posedge core_clk) disable iff (!rst_b)
    ##1 (core_ctrl.ref_select == $past(ref_sel));
  endproperty
  a_ref_select: assert property (p_ref_select) else $error("reference choice not passed on");

  property p_reset_state;
    @(posedge core_clk) disable iff (!rst_b)
    $rose(rst_b) |-> (!enable && !irq_en && !flag && !irq);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset left control bits set");

endmodule // comp_ctrl
`default_nettype wire

// ---- inc/comp_pkg.sv ----
// Shared constants and types for the comparator control block
package comp_pkg;

  // Register map, byte addresses on the AXI4-Lite port
  localparam int unsigned REG_ADDR_W        = 8;
  localparam logic [7:0]  CSR_OFFSET        = 8'h00;
  localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h04;
  localparam logic [7:0]  IRQ_CLEAR_OFFSET  = 8'h08;
  localparam logic [7:0]  IRQ_ENABLE_OFFSET = 8'h0c;
  localparam logic [7:0]  SYSOPT_OFFSET     = 8'h10;

  // Status and control field positions
  localparam int unsigned ENABLE_POS   = 7;
  localparam int unsigned REF_SEL_POS  = 6;
  localparam int unsigned FLAG_POS     = 5;
  localparam int unsigned IRQ_EN_POS   = 4;
  localparam int unsigned RESULT_POS   = 3;
  localparam int unsigned OUT_EN_POS   = 2;
  localparam int unsigned EDGE_SEL_LSB = 0;
  localparam int unsigned ROUTE_POS    = 0;

  // Sticky interrupt status layout
  localparam int unsigned IRQ_W         = 2;
  localparam int unsigned IRQ_EVENT_BIT = 0;
  localparam int unsigned IRQ_WAKE_BIT  = 1;

  // Reset values
  localparam logic [7:0]       CSR_RESET    = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET    = 2'h0;
  localparam logic             SYSOPT_RESET = 1'b0;

  // Input synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Edge selection encodings
  localparam logic [1:0] EDGE_FALL_A = 2'h0;
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  localparam logic [1:0] EDGE_FALL_B = 2'h2;
  localparam logic [1:0] EDGE_BOTH   = 2'h3;

  // Power state reported by the power manager
  typedef enum logic [1:0] {MODE_RUN, MODE_LIGHT_STOP, MODE_DEEP_STOP} power_mode_t;

  // Register selected by an address
  typedef enum logic [2:0] {SEL_CSR, SEL_STATUS, SEL_CLEAR, SEL_ENABLE, SEL_SYSOPT, SEL_NONE} reg_sel_t;

  // Status and control register image
  typedef struct packed {
    logic       enable;
    logic       ref_select;
    logic       flag;
    logic       irq_enable;
    logic       result;
    logic       out_pin_enable;
    logic [1:0] edge_select;
  } csr_t;

  // Controls towards the analog core
  typedef struct packed {
    logic power_on;
    logic ref_select;
  } core_ctrl_t;

  // Output pin level and enable
  typedef struct packed {
    logic level;
    logic oe;
  } pin_out_t;

endpackage

// ---- hdl/comp_sync.sv ----
// Three-stage synchroniser with agreement filter for the comparator output
`timescale 1ns/1ps
`default_nettype none
module comp_sync #(
  parameter int unsigned STAGES = comp_pkg::SYNC_STAGES
) (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_b,
  // Raw level and settled copy
  input  wire logic async_in,
  output logic      settled
);
  import comp_pkg::*;

  logic [STAGES-1:0] chain;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      chain   <= '0;
      settled <= 1'b0;
    end else begin
      chain <= {chain[STAGES-2:0], async_in};
      // Only take a level once the last two stages agree
      if (chain[STAGES-1] == chain[STAGES-2]) begin
        settled <= chain[STAGES-1];
      end
    end
  end

  property p_sync_agree;
    @(posedge core_clk) disable iff (!rst_b)
    (chain[STAGES-1] == chain[STAGES-2]) |=> (settled == $past(chain[STAGES-1]));
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("settled level missed agreeing stages");

endmodule // comp_sync
`default_nettype wire

// ---- hdl/comp_edge.sv ----
// Edge detector that raises a compare event on the selected edge
`timescale 1ns/1ps
`default_nettype none
module comp_edge (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  // Level, arming and edge choice
  input  wire logic       level,
  input  wire logic       armed,
  input  wire logic [1:0] edge_select,
  // One-cycle event
  output logic            hit
);
  import comp_pkg::*;

  logic prev;
  logic was_armed;

  function automatic logic edge_hit(input logic old_lvl, input logic new_lvl, input logic [1:0] sel);
    logic rise;
    logic fall;
    rise = ~old_lvl & new_lvl;
    fall = old_lvl & ~new_lvl;
    unique case (sel)
      EDGE_FALL_A: edge_hit = fall;
      EDGE_RISE:   edge_hit = rise;
      EDGE_FALL_B: edge_hit = fall;
      EDGE_BOTH:   edge_hit = rise | fall;
    endcase
  endfunction

  // History; arming delay keeps an enable from looking like an edge
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      prev      <= 1'b0;
      was_armed <= 1'b0;
    end else begin
      prev      <= level;
      was_armed <= armed;
    end
  end

  assign hit = armed & was_armed & edge_hit(prev, level, edge_select);

endmodule // comp_edge
`default_nettype wire

// ---- tb/comp_core_model.sv ----
// Behavioural analog comparator core with its two input pins
`timescale 1ns/1ps
`default_nettype none
module comp_core_model #(
  parameter logic [7:0] BANDGAP = 8'h28  // Internal reference level, arbitrary units
) (
  // Controls from the block
  input  wire comp_pkg::core_ctrl_t core_ctrl,
  // Pin levels, arbitrary units
  input  wire logic [7:0]           noninverting_input_pin,
  input  wire logic [7:0]           inverting_input_pin,
  // Raw comparison, asynchronous to the block
  output logic                      comp_raw
);
  import comp_pkg::*;
  wire logic [7:0] noninv = core_ctrl.ref_select ? BANDGAP : noninverting_input_pin;
  // high when above; keeps comparing when off, so the block must mask it
  assign comp_raw = noninv > inverting_input_pin;
endmodule // comp_core_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import comp_pkg::*;
  // Clock, reset and bus
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, capture_ch0, capture_pin_blocked, comp_raw;
  logic [1:0]  bresp, rresp;
  core_ctrl_t  core_ctrl;
  pin_out_t    comparator_out_pin;
  power_mode_t power_mode = MODE_RUN;
  logic [7:0]  plus_v = 8'h0a, minus_v = 8'h14;
  int          failures = 0, checks = 0, cycles = 0;

  always #10 core_clk = ~core_clk;

  comp_ctrl u_comp_ctrl (
    .core_clk, .rst_b, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .comp_raw, .core_ctrl, .comparator_out_pin, .power_mode, .capture_ch0, .capture_pin_blocked, .irq
  );
  comp_core_model u_comp_core_model (
    .core_ctrl, .noninverting_input_pin(plus_v), .inverting_input_pin(minus_v), .comp_raw
  );

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Write; readies and response sampled at the rising edge, each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awready === 1'b1)
        awvalid <= 1'b0;
      if (wready === 1'b1)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", 32'(bresp), 32'(RESP_OKAY));
  endtask

  // Read; data and response taken at the edge where rvalid is sampled high
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er, input string n);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arready === 1'b1)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(n, rdata, e);
    chk("rresp", 32'(rresp), 32'(er));
  endtask

  // Synchroniser plus flag plus interrupt fit well inside eight cycles
  task automatic settle;
    repeat (8) @(negedge core_clk);
  endtask

  task automatic pv(input logic [7:0] p, input logic [7:0] m);
    @(posedge core_clk);
    plus_v <= p;
    minus_v <= m;
    settle();
  endtask

  task automatic mode(input power_mode_t pm);
    @(posedge core_clk);
    power_mode <= pm;
    settle();
  endtask

  // Hang guard, well above the expected run length
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    settle();
    chk("irq", 32'(irq), 32'h0);
    rdc(CSR_OFFSET, 32'h0, RESP_OKAY, "csr");
    rdc(8'h14, 32'h0, RESP_SLVERR, "unmapped");
    // Every edge choice, rising then falling
    for (int m = 0; m < 4; m++) begin
      wr(CSR_OFFSET, 32'h80 | m, 4'h1);
      pv(8'h1e, 8'h14);
      chk("irq", 32'(irq), 32'h0);
      rdc(CSR_OFFSET, 32'h88 | m | (m[0] ? 32'h20 : 32'h0), RESP_OKAY, "rise");
      wr(CSR_OFFSET, 32'ha0 | m, 4'h1);
      pv(8'h0a, 8'h14);
      rdc(CSR_OFFSET, 32'h80 | m | (m == 1 ? 32'h0 : 32'h20), RESP_OKAY, "fall");
      wr(CSR_OFFSET, 32'ha0 | m, 4'h1);
    end
    // Interrupt follows the flag; zero write keeps it
    wr(CSR_OFFSET, 32'h91, 4'h1);
    pv(8'h1e, 8'h14);
    chk("irq", 32'(irq), 32'h1);
    wr(CSR_OFFSET, 32'h91, 4'h1);
    rdc(CSR_OFFSET, 32'hb9, RESP_OKAY, "keep");
    wr(CSR_OFFSET, 32'hb1, 4'h1);
    settle();
    chk("irq", 32'(irq), 32'h0);
    // Output pin follows the live result
    wr(CSR_OFFSET, 32'h84, 4'h1);
    settle();
    chk("pin", 32'(comparator_out_pin), 32'h3);
    pv(8'h0a, 8'h14);
    chk("pin", 32'(comparator_out_pin), 32'h1);
    rdc(CSR_OFFSET, 32'ha4, RESP_OKAY, "low");
    wr(CSR_OFFSET, 32'ha0, 4'h1);
    pv(8'h1e, 8'h14);
    chk("pin", 32'(comparator_out_pin), 32'h0);
    // Bandgap against the minus pin, routed to capture
    wr(CSR_OFFSET, 32'hc0, 4'h1);
    pv(8'h0a, 8'h14);
    chk("core", 32'(core_ctrl), 32'h3);
    rdc(CSR_OFFSET, 32'hc8, RESP_OKAY, "ref");
    wr(SYSOPT_OFFSET, 32'h1, 4'h1);
    settle();
    chk("capture", 32'({capture_ch0, capture_pin_blocked}), 32'h3);
    // Disabled: result masked, comparator toggling unseen
    wr(CSR_OFFSET, 32'h43, 4'h1);
    pv(8'h0a, 8'h32);
    pv(8'h0a, 8'h14);
    chk("core", 32'(core_ctrl), 32'h1);
    rdc(CSR_OFFSET, 32'h43, RESP_OKAY, "off");
    // Light stop keeps settings and detects nothing
    wr(CSR_OFFSET, 32'h83, 4'h1);
    mode(MODE_LIGHT_STOP);
    pv(8'h1e, 8'h14);
    chk("core", 32'(core_ctrl), 32'h0);
    pv(8'h0a, 8'h14);
    mode(MODE_RUN);
    rdc(CSR_OFFSET, 32'h83, RESP_OKAY, "resume");
    // Deep stop wake returns the register to reset
    mode(MODE_DEEP_STOP);
    mode(MODE_RUN);
    rdc(CSR_OFFSET, 32'h0, RESP_OKAY, "wake");
    rdc(SYSOPT_OFFSET, 32'h1, RESP_OKAY, "route");
    // Sticky status, mask and clear
    rdc(IRQ_STATUS_OFFSET, 32'h3, RESP_OKAY, "status");
    wr(IRQ_ENABLE_OFFSET, 32'h2, 4'h1);
    settle();
    chk("irq", 32'(irq), 32'h1);
    wr(IRQ_CLEAR_OFFSET, 32'h3, 4'h0);
    rdc(IRQ_STATUS_OFFSET, 32'h3, RESP_OKAY, "nostrobe");
    wr(IRQ_CLEAR_OFFSET, 32'h3, 4'h1);
    settle();
    chk("irq", 32'(irq), 32'h0);
    rdc(IRQ_STATUS_OFFSET, 32'h0, RESP_OKAY, "cleared");
    rdc(IRQ_CLEAR_OFFSET, 32'h0, RESP_OKAY, "clearreg");
    rdc(IRQ_ENABLE_OFFSET, 32'h2, RESP_OKAY, "mask");
    print_verdict();
  end
endmodule // tb
`default_nettype wire
